// file: ccg_pkg.sv
/*
 Constants, register map and types of the clock generation control block.
 Assumes a single 100 MHz core_clk and a plain register port driven by software.
*/
// Summary of operation
// - start on low-speed osc, main oscillator stopped
// - multiplier ten to thirty, half steps
// - main stop forces fallback to low-speed osc
// - no fallback when high-speed osc feeds PLL
// - write protection enabled out of reset
package ccg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [7:0] ADDR_PROTECT = 8'h00;
    localparam logic [7:0] ADDR_OSC = 8'h04;
    localparam logic [7:0] ADDR_PLL = 8'h08;
    localparam logic [7:0] ADDR_SRC = 8'h0C;
    localparam logic [7:0] ADDR_DIV = 8'h10;
    localparam logic [7:0] ADDR_MEMORY_WAIT_SETTING = 8'h14;
    localparam logic [7:0] ADDR_MSTOP_A = 8'h18;
    localparam logic [7:0] ADDR_MSTOP_D = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;

    // oscillator control fields
    localparam int OSC_START_BIT = 0;
    localparam int OSC_DETECT_BIT = 1;
    // pll control fields: multiplier in half steps
    localparam int PLL_MULT_LSB = 0;
    localparam int PLL_MULT_W = 6;
    localparam int PLL_SRC_BIT = 8;
    localparam int PLL_ON_BIT = 16;
    localparam logic [5:0] PLL_MULT_MIN = 6'h14;
    localparam logic [5:0] PLL_MULT_MAX = 6'h3C;
    localparam logic [5:0] PLL_MULT_RESET = 6'h14;
    // status fields
    localparam int STAT_SRC_LSB = 0;
    localparam int STAT_STOP_BIT = 2;
    localparam int STAT_SWITCH_BIT = 3;
    localparam int STAT_ALLSTOP_BIT = 4;

    // divider selector fields, four bits apart, value n divides by 2**n
    localparam int NUM_DIV = 7;
    localparam int DIV_SEL_W = 3;
    localparam int DIV_FIELD_STEP = 4;
    localparam int DIV_CORE = 0;
    localparam int DIV_BUS = 1;
    localparam int DIV_FLASH = 2;
    localparam int DIV_PA = 3;
    localparam int DIV_PB = 4;
    localparam int DIV_PC = 5;
    localparam int DIV_PD = 6;
    localparam logic [31:0] DIV_RESET = 32'h0000_0000;

    // module stop bits that must be set before all-module stop
    localparam logic [31:0] MSTOP_A_NEEDED = 32'h2900_0000;
    localparam logic [7:0] MSTOP_D_NEEDED = 8'hFF;
    localparam logic [31:0] MSTOP_A_RESET = 32'h0000_0000;
    localparam logic [7:0] MSTOP_D_RESET = 8'h00;

    // source change dead time
    localparam int CLK_PERIOD_NS = 10;
    localparam int SWITCH_GAP_NS = 40;
    localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CNT_W = 4;

    typedef enum logic [1:0] {
        SRC_LOW_SPEED,
        SRC_HIGH_SPEED,
        SRC_MAIN,
        SRC_PLL
    } ccg_src_type;

    typedef enum logic {
        SW_RUN,
        SW_GAP
    } ccg_sw_state_type;
endpackage

// file: ccg_div_if.sv
/*
 Carrier between the control logic and one clock enable divider.
 Assumes both ends sit on core_clk.
*/
`timescale 1ns/10ps
interface ccg_div_if;
    import ccg_pkg::*;
    logic [DIV_SEL_W-1:0] ratioSel;
    logic run;
    logic tick;
    modport ctrl (output ratioSel, output run, input tick);
    modport div (input ratioSel, input run, output tick);
endinterface

// file: ccg_clk_div.sv
/*
 One divider that turns core_clk into a one-cycle enable every 2**ratioSel cycles.
 Assumes run drops for at least one cycle around any source change.
*/
`timescale 1ns/10ps
module ccg_clk_div
    import ccg_pkg::*;
#(
    parameter int SEL_W = DIV_SEL_W
)
(
    input wire logic core_clk,
    input wire logic nrst,
    ccg_div_if.div port
);
    localparam int CNT_W = (1 << SEL_W) - 1;

    // the counter width grows as 2**SEL_W, so wide selectors are refused
    if (SEL_W < 1 || SEL_W > 4)
    begin : gBadSel
        $error("ccg_clk_div: SEL_W out of range");
    end

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] lastCount;
    logic atEnd;

    assign lastCount = CNT_W'((1 << port.ratioSel) - 1);
    // >= so a smaller ratio written mid-period wraps at once instead of running long
    assign atEnd = count >= lastCount;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= '0;
            port.tick <= 1'b0;
        end
        else if (!port.run)
        begin
            count <= '0;
            port.tick <= 1'b0;
        end
        else
        begin
            count <= atEnd ? '0 : count + 1'b1;
            port.tick <= atEnd;
        end
    end
endmodule

// file: ccg_clock_gen.sv
/*
 Clock source selection, PLL setup, clock enables and protected registers.
 Assumes mainOscOk is synchronous to core_clk, and software
 keeps divider ratios, memory wait and module stop settings legal.
*/
`timescale 1ns/10ps
module ccg_clock_gen
    import ccg_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [DATA_W-1:0] regRdData,
    input wire logic mainOscOk,
    output logic mainOscEnable,
    output logic pllEnable,
    output logic pllSrcHigh,
    output logic [PLL_MULT_W-1:0] pllMult,
    output logic [1:0] sysClkSel,
    output logic coreClockEn,
    output logic busClockEn,
    output logic flashIfaceClockEn,
    output logic periphClockAEn,
    output logic periphClockBEn,
    output logic periphClockCEn,
    output logic periphClockDEn,
    output logic memoryWaitSetting
);
    logic writeAllowed;
    logic stopDetectEn;
    logic [DATA_W-1:0] divCtrl;
    logic [31:0] moduleStopA;
    logic [7:0] moduleStopD;
    logic stopSeen;
    logic forcedSwitch;
    logic [GAP_CNT_W-1:0] gapCount;
    ccg_src_type target;
    ccg_sw_state_type state;
    ccg_div_if divIf[NUM_DIV] ();

    // register decode
    logic wrProt, wrOsc, wrPll, wrSrc, wrDiv, wrWait, wrStopA, wrStopD, wrStat;
    logic [PLL_MULT_W-1:0] wrMult;
    logic multLegal;
    logic fallbackNeeded;
    logic swRequest;
    logic gapDone;
    logic allStopReady;
    logic [DATA_W-1:0] next_rdData;

    assign wrProt = regWr && regAddr == ADDR_PROTECT;
    assign wrOsc = regWr && writeAllowed && regAddr == ADDR_OSC;
    assign wrPll = regWr && writeAllowed && regAddr == ADDR_PLL;
    assign wrSrc = regWr && writeAllowed && regAddr == ADDR_SRC;
    assign wrDiv = regWr && writeAllowed && regAddr == ADDR_DIV;
    assign wrWait = regWr && writeAllowed && regAddr == ADDR_MEMORY_WAIT_SETTING;
    assign wrStopA = regWr && writeAllowed && regAddr == ADDR_MSTOP_A;
    assign wrStopD = regWr && writeAllowed && regAddr == ADDR_MSTOP_D;
    assign wrStat = regWr && regAddr == ADDR_STATUS;

    assign wrMult = regWrData[PLL_MULT_LSB +: PLL_MULT_W];
    assign multLegal = wrMult >= PLL_MULT_MIN && wrMult <= PLL_MULT_MAX;

    // fallback only when the main oscillator feeds the system clock
    assign fallbackNeeded = stopDetectEn && !mainOscOk
        && (sysClkSel == SRC_MAIN || (sysClkSel == SRC_PLL && !pllSrcHigh));
    // the PLL is entered only through this software write
    assign swRequest = wrSrc && regWrData[1:0] != sysClkSel;
    assign gapDone = gapCount == GAP_CNT_W'(SWITCH_GAP_CYC - 1);
    assign allStopReady = (moduleStopA & MSTOP_A_NEEDED) == MSTOP_A_NEEDED
        && moduleStopD == MSTOP_D_NEEDED;

    always_comb
    begin
        next_rdData = '0;
        case (regAddr)
            ADDR_PROTECT: next_rdData[0] = writeAllowed;
            ADDR_OSC:
            begin
                next_rdData[OSC_START_BIT] = mainOscEnable;
                next_rdData[OSC_DETECT_BIT] = stopDetectEn;
            end
            ADDR_PLL:
            begin
                next_rdData[PLL_MULT_LSB +: PLL_MULT_W] = pllMult;
                next_rdData[PLL_SRC_BIT] = pllSrcHigh;
                next_rdData[PLL_ON_BIT] = pllEnable;
            end
            ADDR_SRC: next_rdData[1:0] = target;
            ADDR_DIV: next_rdData = divCtrl;
            ADDR_MEMORY_WAIT_SETTING: next_rdData[0] = memoryWaitSetting;
            ADDR_MSTOP_A: next_rdData = moduleStopA;
            ADDR_MSTOP_D: next_rdData[7:0] = moduleStopD;
            ADDR_STATUS:
            begin
                next_rdData[STAT_SRC_LSB +: 2] = sysClkSel;
                next_rdData[STAT_STOP_BIT] = stopSeen;
                next_rdData[STAT_SWITCH_BIT] = state == SW_GAP;
                next_rdData[STAT_ALLSTOP_BIT] = allStopReady;
            end
            default: next_rdData = '0;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            regRdData <= '0;
        else
            regRdData <= regRd ? next_rdData : '0;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            writeAllowed <= 1'b0;
        else if (wrProt)
            writeAllowed <= regWrData[0];
    end

    // main oscillator held stopped until software starts it
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mainOscEnable <= 1'b0;
            stopDetectEn <= 1'b0;
        end
        else if (wrOsc)
        begin
            mainOscEnable <= regWrData[OSC_START_BIT];
            stopDetectEn <= regWrData[OSC_DETECT_BIT];
        end
    end

    // illegal multipliers leave the old value
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pllMult <= PLL_MULT_RESET;
            pllSrcHigh <= 1'b0;
            pllEnable <= 1'b0;
        end
        else if (wrPll)
        begin
            if (multLegal)
                pllMult <= wrMult;
            pllSrcHigh <= regWrData[PLL_SRC_BIT];
            pllEnable <= regWrData[PLL_ON_BIT];
        end
    end

    // memory wait is a software setting
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            divCtrl <= DIV_RESET;
            memoryWaitSetting <= 1'b0;
            moduleStopA <= MSTOP_A_RESET;
            moduleStopD <= MSTOP_D_RESET;
        end
        else
        begin
            if (wrDiv)
                divCtrl <= regWrData;
            if (wrWait)
                memoryWaitSetting <= regWrData[0];
            if (wrStopA)
                moduleStopA <= regWrData;
            if (wrStopD)
                moduleStopD <= regWrData[7:0];
        end
    end

    // sticky stop flag: a new stop wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            stopSeen <= 1'b0;
        else if (stopDetectEn && !mainOscOk)
            stopSeen <= 1'b1;
        else if (wrStat && regWrData[STAT_STOP_BIT])
            stopSeen <= 1'b0;
    end

    // dividers halt for a fixed gap across every source change
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= SW_RUN;
            sysClkSel <= SRC_LOW_SPEED;
            target <= SRC_LOW_SPEED;
            gapCount <= '0;
            forcedSwitch <= 1'b0;
        end
        else
        begin
            case (state)
                SW_RUN:
                begin
                    gapCount <= '0;
                    // forced fallback beats a software request
                    if (fallbackNeeded)
                    begin
                        target <= SRC_LOW_SPEED;
                        forcedSwitch <= 1'b1;
                        state <= SW_GAP;
                    end
                    else if (swRequest)
                    begin
                        target <= ccg_src_type'(regWrData[1:0]);
                        forcedSwitch <= 1'b0;
                        state <= SW_GAP;
                    end
                end
                SW_GAP:
                begin
                    gapCount <= gapCount + 1'b1;
                    if (gapDone)
                    begin
                        sysClkSel <= target;
                        state <= SW_RUN;
                    end
                end
                default: state <= SW_RUN;
            endcase
        end
    end

    for (genvar i = 0; i < NUM_DIV; i++)
    begin : gDiv
        assign divIf[i].ratioSel = divCtrl[i*DIV_FIELD_STEP +: DIV_SEL_W];
        assign divIf[i].run = state == SW_RUN;
        ccg_clk_div #(.SEL_W(DIV_SEL_W)) uDiv (
            .core_clk(core_clk),
            .nrst(nrst),
            .port(divIf[i])
        );
    end

    assign coreClockEn = divIf[DIV_CORE].tick;
    assign busClockEn = divIf[DIV_BUS].tick;
    assign flashIfaceClockEn = divIf[DIV_FLASH].tick;
    assign periphClockAEn = divIf[DIV_PA].tick;
    assign periphClockBEn = divIf[DIV_PB].tick;
    assign periphClockCEn = divIf[DIV_PC].tick;
    assign periphClockDEn = divIf[DIV_PD].tick;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    a_osc_start_sw: assert property ($rose(mainOscEnable) |-> $past(wrOsc))
        else $error("main oscillator started without a permitted write");
    a_mult_range: assert property (pllMult >= PLL_MULT_MIN && pllMult <= PLL_MULT_MAX)
        else $error("pll multiplier outside legal range");
    a_pll_by_sw: assert property ($rose(state == SW_GAP) && target == SRC_PLL |->
        $past(wrSrc) && $past(regWrData[1:0]) == SRC_PLL && !forcedSwitch)
        else $error("pll selected without software request");
    a_stop_fallback: assert property (state == SW_RUN && fallbackNeeded |=>
        state == SW_GAP && target == SRC_LOW_SPEED ##4 sysClkSel == SRC_LOW_SPEED)
        else $error("no fallback after main oscillator stop");
    a_high_pll_kept: assert property (state == SW_RUN && !swRequest && sysClkSel == SRC_PLL
        && pllSrcHigh |=> state == SW_RUN && sysClkSel == SRC_PLL)
        else $error("pll from high speed osc changed over");
    a_protect_block: assert property (regWr && !writeAllowed && regAddr == ADDR_PLL
        |=> $stable(pllMult) && $stable(pllEnable) && $stable(pllSrcHigh))
        else $error("protected register written while locked");
    a_gap_quiet: assert property (state == SW_GAP |=> !coreClockEn && !periphClockAEn)
        else $error("clock enable pulsed during source change");
    a_gap_length: assert property ($rose(state == SW_GAP) |->
        (state == SW_GAP)[*4] ##1 state == SW_RUN)
        else $error("source change gap has wrong length");
    a_status_read: assert property (regRd && regAddr == ADDR_STATUS |=>
        regRdData[1:0] == $past(sysClkSel) && regRdData[2] == $past(stopSeen))
        else $error("status read returned wrong value");

    c_forced_fallback: cover property (fallbackNeeded ##5 sysClkSel == SRC_LOW_SPEED);
    c_switch_pll: cover property (swRequest && regWrData[1:0] == SRC_PLL);
    c_blocked_write: cover property (regWr && !writeAllowed && regAddr == ADDR_OSC);
    c_set_over_clear: cover property (stopDetectEn && !mainOscOk && wrStat
        && regWrData[STAT_STOP_BIT]);
endmodule

// file: tb_top.sv
/*
 Self-checking testbench for the clock generation control block.
 Assumes the ccg_pkg register map and a 100 MHz core_clk; the bench drives
 every input itself, with no model on the far side.
*/
`timescale 1ns/10ps
module tb_top
    import ccg_pkg::*;
;
    logic core_clk;
    logic nrst;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic regWr;
    logic regRd;
    logic [DATA_W-1:0] regRdData;
    logic mainOscOk;
    logic mainOscEnable;
    logic pllEnable;
    logic pllSrcHigh;
    logic [PLL_MULT_W-1:0] pllMult;
    logic [1:0] sysClkSel;
    logic coreClockEn;
    logic busClockEn;
    logic flashIfaceClockEn;
    logic periphClockAEn;
    logic periphClockBEn;
    logic periphClockCEn;
    logic periphClockDEn;
    logic memoryWaitSetting;
    int badCount = 0;
    int checks = 0;
    logic rdSeen = 1'b0;
    logic [31:0] expQ[$];
    logic [31:0] maskQ[$];

    ccg_clock_gen DUT (
        .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .mainOscOk(mainOscOk),
        .mainOscEnable(mainOscEnable), .pllEnable(pllEnable), .pllSrcHigh(pllSrcHigh),
        .pllMult(pllMult), .sysClkSel(sysClkSel), .coreClockEn(coreClockEn),
        .busClockEn(busClockEn), .flashIfaceClockEn(flashIfaceClockEn),
        .periphClockAEn(periphClockAEn), .periphClockBEn(periphClockBEn),
        .periphClockCEn(periphClockCEn), .periphClockDEn(periphClockDEn),
        .memoryWaitSetting(memoryWaitSetting)
    );

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    task automatic stopTest();
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] addr, logic [31:0] data);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= addr;
        regWrData <= data;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    // the expected word is noted before the strobe is sampled
    task automatic rd(logic [7:0] addr, logic [31:0] exp, logic [31:0] mask);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= addr;
        expQ.push_back(exp);
        maskQ.push_back(mask);
        @(posedge core_clk);
        regRd <= 1'b0;
    endtask

    task automatic waitSel(logic [1:0] exp);
        int i;
        for (i = 0; i < 30; i++)
        begin
            @(posedge core_clk);
            #1;
            if (sysClkSel === exp)
                break;
        end
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge core_clk)
    begin
        logic [31:0] e;
        logic [31:0] m;
        if (rdSeen && expQ.size() > 0)
        begin
            e = expQ.pop_front();
            m = maskQ.pop_front();
            check("regRdData", regRdData & m, e);
        end
        rdSeen <= regRd;
    end

    initial
    begin
        repeat (5000) @(posedge core_clk);
        badCount++;
        stopTest();
    end

    initial
    begin
        logic [5:0] cur;
        logic [5:0] v;
        int i;
        int cnt[7];
        logic [5:0] tbl[6];
        void'($urandom(99415));
        nrst = 1'b0;
        regAddr = '0;
        regWrData = '0;
        regWr = 1'b0;
        regRd = 1'b0;
        mainOscOk = 1'b1;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        #1;
        check("sysClkSel", sysClkSel, 0);
        check("mainOscEnable", mainOscEnable, 0);
        check("pllMult", pllMult, PLL_MULT_RESET);
        wr(ADDR_OSC, 32'h0000_0003);
        wr(ADDR_MEMORY_WAIT_SETTING, 32'h0000_0001);
        #1;
        check("mainOscEnable", mainOscEnable, 0);
        check("memoryWaitSetting", memoryWaitSetting, 0);
        rd(ADDR_OSC, 32'h0000_0000, 32'hFFFF_FFFF);
        wr(ADDR_PROTECT, 32'h0000_0001);
        wr(ADDR_OSC, 32'h0000_0003);
        #1;
        check("mainOscEnable", mainOscEnable, 1);
        rd(ADDR_OSC, 32'h0000_0003, 32'h0000_0003);
        wr(ADDR_MEMORY_WAIT_SETTING, 32'h0000_0001);
        #1;
        check("memoryWaitSetting", memoryWaitSetting, 1);
        wr(8'h40, $urandom());
        rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
        // boundaries, both neighbours outside, then random legal values
        tbl = '{6'h14, 6'h3C, 6'h13, 6'h3D, 6'h00, 6'h00};
        tbl[4] = 6'(20 + $urandom_range(40));
        tbl[5] = 6'(20 + $urandom_range(40));
        cur = PLL_MULT_RESET;
        for (i = 0; i < 6; i++)
        begin
            v = tbl[i];
            if (v >= 6'h14 && v <= 6'h3C)
                cur = v;
            wr(ADDR_PLL, {26'h0, v});
            #1;
            check("pllMult", pllMult, cur);
            rd(ADDR_PLL, {26'h0, cur}, 32'h0000_003F);
        end
        wr(ADDR_PLL, 32'h0001_0014);
        repeat (8) @(posedge core_clk);
        #1;
        check("sysClkSel", sysClkSel, 0);
        check("pllEnable", pllEnable, 1);
        wr(ADDR_SRC, 32'h0000_0002);
        repeat (3) @(posedge core_clk);
        #1;
        check("coreClockEn", coreClockEn, 0);
        waitSel(2'd2);
        check("sysClkSel", sysClkSel, 2);
        @(posedge core_clk);
        mainOscOk <= 1'b0;
        waitSel(2'd0);
        check("sysClkSel", sysClkSel, 0);
        rd(ADDR_STATUS, 32'h0000_0004, 32'h0000_0007);
        @(posedge core_clk);
        mainOscOk <= 1'b1;
        wr(ADDR_PLL, 32'h0001_013C);
        #1;
        check("pllSrcHigh", pllSrcHigh, 1);
        wr(ADDR_SRC, 32'h0000_0003);
        waitSel(2'd3);
        check("sysClkSel", sysClkSel, 3);
        @(posedge core_clk);
        mainOscOk <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        check("sysClkSel", sysClkSel, 3);
        // same stop, but now the main oscillator feeds the loop
        wr(ADDR_PLL, 32'h0001_003C);
        #1;
        check("pllSrcHigh", pllSrcHigh, 0);
        waitSel(2'd0);
        check("sysClkSel", sysClkSel, 0);
        // legal set: core 1/4, bus 1/4, flash 1/8, A 1/8, B 1/8, C 1/4, D 1/16
        wr(ADDR_DIV, 32'h0423_3322);
        repeat (8) @(posedge core_clk);
        cnt = '{default: 0};
        repeat (32)
        begin
            @(posedge core_clk);
            #1;
            cnt[0] += int'(coreClockEn === 1'b1);
            cnt[1] += int'(busClockEn === 1'b1);
            cnt[2] += int'(flashIfaceClockEn === 1'b1);
            cnt[3] += int'(periphClockAEn === 1'b1);
            cnt[4] += int'(periphClockBEn === 1'b1);
            cnt[5] += int'(periphClockCEn === 1'b1);
            cnt[6] += int'(periphClockDEn === 1'b1);
        end
        check("coreClockEn count", 32'(cnt[0]), 32'h0000_0008);
        check("busClockEn count", 32'(cnt[1]), 32'h0000_0008);
        check("flashIfaceClockEn count", 32'(cnt[2]), 32'h0000_0004);
        check("periphClockAEn count", 32'(cnt[3]), 32'h0000_0004);
        check("periphClockBEn count", 32'(cnt[4]), 32'h0000_0004);
        check("periphClockCEn count", 32'(cnt[5]), 32'h0000_0008);
        check("periphClockDEn count", 32'(cnt[6]), 32'h0000_0002);
        // a clear while the stop still stands must lose
        wr(ADDR_STATUS, 32'h0000_0004);
        rd(ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
        mainOscOk <= 1'b1;
        wr(ADDR_STATUS, 32'h0000_0004);
        rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0004);
        wr(ADDR_MSTOP_A, MSTOP_A_NEEDED);
        wr(ADDR_MSTOP_D, 32'h0000_007F);
        rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0010);
        wr(ADDR_MSTOP_D, 32'h0000_00FF);
        rd(ADDR_STATUS, 32'h0000_0010, 32'h0000_0010);
        // second reset: let the last read data be taken first
        @(posedge core_clk);
        nrst <= 1'b0;
        @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        #1;
        check("sysClkSel", sysClkSel, 0);
        check("pllMult", pllMult, PLL_MULT_RESET);
        wr(ADDR_OSC, 32'h0000_0003);
        #1;
        check("mainOscEnable", mainOscEnable, 0);
        repeat (4) @(posedge core_clk);
        stopTest();
    end
endmodule
